// ### phase_source.sv
/*
 * Voltage channel model: three balanced fundamental phasors and a block line.
 * Assumes the bench sets magnitude, phase order and block level on ref_clk.
 */
module phase_source import seq_volt_pkg::*; (
    input logic ref_clk,
    input logic sys_rst,
    input logic [15:0] mag,
    input logic neg_order,
    input logic blk,
    output phasor_s [2:0] phase_fund,
    output logic block_in
);
    logic signed [31:0] h;
    logic signed [31:0] q;
    assign h = -($signed({16'h0000, mag}) >>> 1);
    // Sine of 120 degrees in Q15
    assign q = ($signed({16'h0000, mag}) * 32'sh6eda) >>> 15;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_fund <= '0;
            block_in <= 1'b0;
        end else begin
            phase_fund[0] <= '{mag, 16'h0000};
            phase_fund[1] <= '{h[15:0], neg_order ? q[15:0] : -q[15:0]};
            phase_fund[2] <= '{h[15:0], neg_order ? -q[15:0] : q[15:0]};
            block_in <= blk;
        end
    end
endmodule

// ### seq_component_calc.sv
/*
 * Symmetric component and phase magnitude calculation, one result per go pulse.
 * Assumes phase inputs are fundamental-frequency phasors on the same clock.
 */
module seq_component_calc import seq_volt_pkg::*; (
    input logic ref_clk,
    input logic sys_rst,
    input logic go,
    input logic neg_sel,
    input phasor_s [2:0] phase_fund,
    output logic done,
    output logic [MAG_W-1:0] seq_mag,
    output logic [2:0][MAG_W-1:0] ph_mag
);
    typedef struct packed {
        logic done;
        logic [MAG_W-1:0] seq;
        logic [2:0][MAG_W-1:0] ph;
    } calc_st_s;

    calc_st_s q;
    calc_st_s d;
    logic [2:0][MAG_W-1:0] phm;

    // Rotation by 120 degrees, or by 240 degrees when sq is set
    function automatic cplx_s rot(input phasor_s p, input logic sq);
        logic signed [35:0] sx;
        logic signed [35:0] sy;
        logic signed [MAG_W-1:0] hx;
        logic signed [MAG_W-1:0] hy;
        logic signed [MAG_W-1:0] tx;
        logic signed [MAG_W-1:0] ty;
        cplx_s r;
        sx = SIN120_Q15 * p.re;
        sy = SIN120_Q15 * p.im;
        hx = MAG_W'(p.re) >>> 1;
        hy = MAG_W'(p.im) >>> 1;
        tx = MAG_W'(sx >>> Q_SHIFT);
        ty = MAG_W'(sy >>> Q_SHIFT);
        r.re = sq ? (ty - hx) : (-hx - ty);
        r.im = sq ? (-tx - hy) : (tx - hy);
        return r;
    endfunction

    // Magnitude estimate, larger of max and 7/8 max + min/2; exact on the axes
    function automatic logic [MAG_W-1:0] mag_est(input logic signed [MAG_W-1:0] re,
                                                 input logic signed [MAG_W-1:0] im);
        logic [MAG_W-1:0] a;
        logic [MAG_W-1:0] b;
        logic [MAG_W-1:0] hi;
        logic [MAG_W-1:0] lo;
        logic [MAG_W-1:0] est;
        a = re[MAG_W-1] ? MAG_W'(-re) : MAG_W'(re);
        b = im[MAG_W-1] ? MAG_W'(-im) : MAG_W'(im);
        hi = (a > b) ? a : b;
        lo = (a > b) ? b : a;
        est = hi - (hi >> 3) + (lo >> 1);
        return (est > hi) ? est : hi;
    endfunction

    for (genvar i = 0; i < 3; i++) begin : g_ph
        assign phm[i] = mag_est(MAG_W'(phase_fund[i].re), MAG_W'(phase_fund[i].im));
    end

    always_comb begin
        cplx_s r2;
        cplx_s r3;
        logic signed [MAG_W-1:0] sre;
        logic signed [MAG_W-1:0] sim;
        logic signed [35:0] pre;
        logic signed [35:0] pim;
        d = q;
        r2 = rot(phase_fund[1], neg_sel);
        r3 = rot(phase_fund[2], !neg_sel);
        sre = MAG_W'(phase_fund[0].re) + r2.re + r3.re;
        sim = MAG_W'(phase_fund[0].im) + r2.im + r3.im;
        pre = THIRD_Q15 * sre;
        pim = THIRD_Q15 * sim;
        d.done = go;
        if (go) begin
            d.seq = mag_est(MAG_W'(pre >>> Q_SHIFT), MAG_W'(pim >>> Q_SHIFT));
            d.ph = phm;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;
    assign seq_mag = q.seq;
    assign ph_mag = q.ph;
endmodule

// ### seq_divider.sv
/*
 * Unsigned restoring divider, DIV_W cycles per result; zero divisor gives all ones.
 * Assumes num and den are stable in the cycle that go is high.
 */
module seq_divider import seq_volt_pkg::*; (
    input logic ref_clk,
    input logic sys_rst,
    input logic go,
    input logic [DIV_W-1:0] num,
    input logic [DIV_W-1:0] den,
    output logic done,
    output logic [DIV_W-1:0] quo
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
        logic [DIV_W:0] rem;
        logic [DIV_W-1:0] quo;
        logic [DIV_W-1:0] den;
    } div_st_s;

    div_st_s q;
    div_st_s d;

    always_comb begin
        logic [DIV_W:0] sh;
        sh = {q.rem[DIV_W-1:0], q.quo[DIV_W-1]};
        d = q;
        d.done = 1'b0;
        if (go) begin
            d.busy = 1'b1;
            d.cnt = 6'(DIV_W);
            d.rem = '0;
            d.quo = num;
            d.den = den;
        end else if (q.busy) begin
            if (sh >= {1'b0, q.den}) begin
                d.rem = sh - {1'b0, q.den};
                d.quo = {q.quo[DIV_W-2:0], 1'b1};
            end else begin
                d.rem = sh;
                d.quo = {q.quo[DIV_W-2:0], 1'b0};
            end
            d.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h01) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;
    assign quo = q.quo;
endmodule

// ### seq_volt_pkg.sv
/*
 * Shared constants, register map and carrier types of the sequence voltage stage.
 * Assumes one 100 MHz clock; magnitudes use one LSB per 0.01 % of nominal voltage.
 */
package seq_volt_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int STEP_US = 5000;
    localparam int PROG_CYCLE_DEF = CLK_HZ / 1_000_000 * STEP_US;
    localparam int DIV_W = 40;
    localparam int MAG_W = 18;
    localparam int Q_SHIFT = 15;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PICK = 8'h04;
    localparam logic [7:0] OFF_UNDER_BLOCK_LEVEL = 8'h08;
    localparam logic [7:0] OFF_OPTIME = 8'h0c;
    localparam logic [7:0] OFF_KDIAL = 8'h10;
    localparam logic [7:0] OFF_VT = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_MAG = 8'h1c;
    localparam logic [7:0] OFF_RATIO = 8'h20;
    localparam logic [7:0] OFF_EXPT = 8'h24;
    localparam logic [7:0] OFF_REMAIN = 8'h28;
    localparam logic [7:0] OFF_PRI = 8'h2c;

    localparam logic [13:0] PICK_DEF = 14'h2904;
    localparam logic [13:0] PICK_MIN = 14'h01f4;
    localparam logic [13:0] PICK_MAX = 14'h3a98;
    localparam logic [13:0] UNDER_BLOCK_LEVEL_DEF = 14'h01f4;
    localparam logic [13:0] UNDER_BLOCK_LEVEL_MAX = 14'h1f40;
    localparam logic [18:0] OPT_DEF = 19'h00008;
    localparam logic [18:0] OPT_MAX = 19'h57e40;
    localparam logic [12:0] KDIAL_DEF = 13'h0005;
    // Arbitrary default primary scaling, 0.1 V units
    localparam logic [23:0] VT_DEF = 24'h0003e8;

    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [7:0] REL_OVER = 8'h61;
    localparam logic [7:0] REL_UNDER = 8'h67;
    localparam logic [7:0] INV_SCALE = 8'hc8;
    localparam logic [15:0] PRI_DIV = 16'h2710;
    localparam logic signed [17:0] SIN120_Q15 = 18'sh06eda;
    localparam logic signed [17:0] THIRD_Q15 = 18'sh02aab;

    typedef enum logic [1:0] {
        FORCE_NORMAL = 2'b00,
        FORCE_START = 2'b01,
        FORCE_TRIP = 2'b10,
        FORCE_BLOCKED = 2'b11
    } force_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CALC = 3'b001,
        ST_RATIO = 3'b010,
        ST_TIME = 3'b011,
        ST_EVAL = 3'b100
    } state_e;

    typedef struct packed {
        logic time_inv;
        force_e force_sel;
        logic force_en;
        logic under;
        logic neg;
    } ctrl_s;

    typedef struct packed {
        logic signed [15:0] re;
        logic signed [15:0] im;
    } phasor_s;

    typedef struct packed {
        logic signed [MAG_W-1:0] re;
        logic signed [MAG_W-1:0] im;
    } cplx_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;
endpackage

// ### sequence_voltage_stage.sv
/*
 * Sequence voltage protection stage: symmetric components, pick-up with hysteresis,
 * undervoltage block, definite or inverse-time trip, diagnostics over APB.
 * Assumes phasors and block input come from logic on ref_clk.
 */
//
// Contract
// - Positive component is third of L1 plus a*L2 plus a^2*L3.
// - Negative component is third of L1 plus a^2*L2 plus a*L3.
// - Only fundamental phasors of each channel feed the components.
// - Static select picks positive or negative magnitude, positive by default.
// - Force setting overrides outputs while forcing enable is set; default normal.
// - Pick-up when magnitude crosses programmable level, 0.01 % nominal steps.
// - Over mode releases only below 97 % of level.
// - Under mode releases only above 103 % of level.
// - Direction setting selects over or under; default over.
// - Under block level settable in 0.01 % steps, default 5 %.
// - Under mode withholds trip while voltage below block level.
// - Engaged block holds until every line voltage exceeds pick-up level.
// - Block level zero disables the undervoltage block.
// - Pick-up settings change while running and govern later comparisons.
// - Magnitude select and force setting are static general settings.
// - Expected operating time in 5 ms steps, recomputed in inverse mode.
// - Remaining time to trip reported signed in 5 ms steps.
// - Measured to pick-up ratio reported continuously in 0.01 steps.
// - Pick-up level reported in primary volts, 0.1 V steps.
// - Pick-up gives start unless block active, then blocked only.
// - Block input sampled at start of each program cycle.
module sequence_voltage_stage import seq_volt_pkg::*; #(
    parameter int PROG_CYCLE_CYCLES = PROG_CYCLE_DEF
) (
    input logic ref_clk,
    input logic sys_rst,
    input apb_req_s apb,
    output apb_rsp_s apb_rsp,
    input phasor_s [2:0] phase_fund,
    input logic block_in,
    output logic stage_start,
    output logic stage_trip,
    output logic stage_blocked
);
    localparam logic [31:0] TICK_LAST = 32'(PROG_CYCLE_CYCLES - 1);

    typedef struct packed {
        state_e state;
        logic [31:0] tick;
        ctrl_s ctrl;
        logic [13:0] pick;
        logic [13:0] under_block_level;
        logic [18:0] optime;
        logic [12:0] kdial;
        logic [23:0] vt;
        logic calc_go;
        logic div_go;
        logic time_go;
        logic blk_s;
        logic picked;
        logic under_block_level_on;
        logic start;
        logic trip;
        logic blocked;
        logic [MAG_W-1:0] mag;
        logic [2:0][MAG_W-1:0] ph;
        logic [31:0] ratio;
        logic [31:0] pri;
        logic [31:0] exp_t;
        logic [31:0] elapsed;
        logic signed [31:0] remain;
        logic [2:0] out;
        apb_rsp_s rsp;
    } st_s;

    st_s q;
    st_s d;
    logic calc_done;
    logic [MAG_W-1:0] calc_mag;
    logic [2:0][MAG_W-1:0] calc_ph;
    logic div_done;
    logic [DIV_W-1:0] ratio_quo;
    logic [DIV_W-1:0] pri_quo;
    logic time_done;
    logic [DIV_W-1:0] time_quo;
    logic [DIV_W-1:0] tden;
    logic pk_n;
    logic ub_n;

    seq_component_calc u_calc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .go(q.calc_go),
        .neg_sel(q.ctrl.neg),
        .phase_fund(phase_fund),
        .done(calc_done),
        .seq_mag(calc_mag),
        .ph_mag(calc_ph)
    );

    seq_divider u_ratio (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .go(q.div_go),
        .num(DIV_W'(q.mag) * DIV_W'(PCT_FULL)),
        .den(DIV_W'(q.pick)),
        .done(div_done),
        .quo(ratio_quo)
    );

    seq_divider u_pri (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .go(q.div_go),
        .num(DIV_W'(q.pick) * DIV_W'(q.vt)),
        .den(DIV_W'(PRI_DIV)),
        .done(),
        .quo(pri_quo)
    );

    seq_divider u_time (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .go(q.time_go),
        .num(DIV_W'(q.kdial) * DIV_W'(INV_SCALE)),
        .den(tden),
        .done(time_done),
        .quo(time_quo)
    );

    // Distance of ratio from unity on the picking side; zero saturates the result
    always_comb begin
        tden = '0;
        if (q.ctrl.under && q.ratio < 32'(PCT_FULL)) begin
            tden = DIV_W'(32'(PCT_FULL) - q.ratio);
        end else if (!q.ctrl.under && q.ratio > 32'(PCT_FULL)) begin
            tden = DIV_W'(q.ratio - 32'(PCT_FULL));
        end
    end

    always_comb begin
        logic hit;
        logic [31:0] rdata;
        logic [31:0] m100;
        logic [31:0] p97;
        logic [31:0] p103;
        logic above;
        logic [31:0] el_n;
        d = q;
        hit = 1'b1;
        rdata = '0;
        m100 = 32'(q.mag) * 32'(PCT_FULL);
        p97 = 32'(q.pick) * 32'(REL_OVER);
        p103 = 32'(q.pick) * 32'(REL_UNDER);
        above = (q.ph[0] > MAG_W'(q.pick)) && (q.ph[1] > MAG_W'(q.pick))
            && (q.ph[2] > MAG_W'(q.pick));
        el_n = q.elapsed + 32'h1;
        pk_n = q.picked;
        ub_n = q.under_block_level_on;
        d.calc_go = 1'b0;
        d.div_go = 1'b0;
        d.time_go = 1'b0;
        d.rsp.pready = 1'b0;
        d.tick = (q.tick == TICK_LAST) ? '0 : q.tick + 32'h1;

        case (apb.paddr)
            OFF_CTRL: rdata = 32'(q.ctrl);
            OFF_PICK: rdata = 32'(q.pick);
            OFF_UNDER_BLOCK_LEVEL: rdata = 32'(q.under_block_level);
            OFF_OPTIME: rdata = 32'(q.optime);
            OFF_KDIAL: rdata = 32'(q.kdial);
            OFF_VT: rdata = 32'(q.vt);
            OFF_STATUS: rdata = 32'({q.out, q.under_block_level_on, q.blocked, q.trip, q.start, q.picked});
            OFF_MAG: rdata = 32'(q.mag);
            OFF_RATIO: rdata = q.ratio;
            OFF_EXPT: rdata = q.exp_t;
            OFF_REMAIN: rdata = q.remain;
            OFF_PRI: rdata = q.pri;
            default: hit = 1'b0;
        endcase
        if (apb.psel && apb.penable && !q.rsp.pready) begin
            d.rsp.pready = 1'b1;
            d.rsp.pslverr = !hit;
            d.rsp.prdata = rdata;
        end
        if (apb.psel && apb.penable && q.rsp.pready && apb.pwrite) begin
            case (apb.paddr)
                OFF_CTRL: d.ctrl = ctrl_s'(apb.pwdata[$bits(ctrl_s)-1:0]);
                OFF_PICK: begin
                    if (apb.pwdata > 32'(PICK_MAX)) begin
                        d.pick = PICK_MAX;
                    end else if (apb.pwdata < 32'(PICK_MIN)) begin
                        d.pick = PICK_MIN;
                    end else begin
                        d.pick = apb.pwdata[13:0];
                    end
                end
                OFF_UNDER_BLOCK_LEVEL: begin
                    d.under_block_level = (apb.pwdata > 32'(UNDER_BLOCK_LEVEL_MAX)) ? UNDER_BLOCK_LEVEL_MAX : apb.pwdata[13:0];
                end
                OFF_OPTIME: begin
                    d.optime = (apb.pwdata > 32'(OPT_MAX)) ? OPT_MAX : apb.pwdata[18:0];
                end
                OFF_KDIAL: d.kdial = apb.pwdata[12:0];
                OFF_VT: d.vt = apb.pwdata[23:0];
                default: ;
            endcase
        end

        case (q.state)
            ST_IDLE: begin
                if (q.tick == TICK_LAST) begin
                    d.blk_s = block_in;
                    d.calc_go = 1'b1;
                    d.state = ST_CALC;
                end
            end
            ST_CALC: begin
                if (calc_done) begin
                    d.mag = calc_mag;
                    d.ph = calc_ph;
                    d.div_go = 1'b1;
                    d.state = ST_RATIO;
                end
            end
            ST_RATIO: begin
                if (div_done) begin
                    d.ratio = ratio_quo[31:0];
                    d.pri = pri_quo[31:0];
                    d.time_go = 1'b1;
                    d.state = ST_TIME;
                end
            end
            ST_TIME: begin
                if (time_done) begin
                    if (!q.ctrl.time_inv) begin
                        d.exp_t = 32'(q.optime);
                    end else if (time_quo > DIV_W'(OPT_MAX)) begin
                        d.exp_t = 32'(OPT_MAX);
                    end else begin
                        d.exp_t = time_quo[31:0];
                    end
                    d.state = ST_EVAL;
                end
            end
            ST_EVAL: begin
                if (!q.ctrl.under) begin
                    pk_n = q.picked ? (m100 >= p97) : (q.mag > MAG_W'(q.pick));
                end else begin
                    pk_n = q.picked ? (m100 <= p103) : (q.mag < MAG_W'(q.pick));
                end
                if (q.under_block_level == '0 || !q.ctrl.under) begin
                    ub_n = 1'b0;
                end else begin
                    ub_n = q.under_block_level_on ? !above : (q.mag < MAG_W'(q.under_block_level));
                end
                d.picked = pk_n;
                d.under_block_level_on = ub_n;
                if (!pk_n) begin
                    d.start = 1'b0;
                    d.blocked = 1'b0;
                    d.trip = 1'b0;
                    d.elapsed = '0;
                    d.remain = '0;
                end else if (q.blk_s) begin
                    d.blocked = 1'b1;
                    d.start = 1'b0;
                    d.trip = 1'b0;
                    d.elapsed = '0;
                    d.remain = '0;
                end else begin
                    d.start = 1'b1;
                    d.blocked = 1'b0;
                    d.elapsed = (el_n == '0) ? q.elapsed : el_n;
                    d.trip = !ub_n && (el_n >= q.exp_t);
                    d.remain = $signed(q.exp_t - el_n);
                end
                d.state = ST_IDLE;
            end
            default: d.state = ST_IDLE;
        endcase

        if (q.ctrl.force_en) begin
            case (q.ctrl.force_sel)
                FORCE_START: d.out = 3'b001;
                FORCE_TRIP: d.out = 3'b010;
                FORCE_BLOCKED: d.out = 3'b100;
                default: d.out = 3'b000;
            endcase
        end else begin
            d.out = {q.blocked, q.trip, q.start};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.pick <= PICK_DEF;
            q.under_block_level <= UNDER_BLOCK_LEVEL_DEF;
            q.optime <= OPT_DEF;
            q.kdial <= KDIAL_DEF;
            q.vt <= VT_DEF;
        end else begin
            q <= d;
        end
    end

    assign apb_rsp = q.rsp;
    assign stage_start = q.out[0];
    assign stage_trip = q.out[1];
    assign stage_blocked = q.out[2];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_force_trip: assert property (
        q.ctrl.force_en && q.ctrl.force_sel == FORCE_TRIP |=> stage_trip && !stage_start)
        else $error("forced trip not shown");
    a_over_release: assert property (
        q.state == ST_EVAL && !q.ctrl.under && q.picked
        && 32'(q.mag) * 32'(PCT_FULL) < 32'(q.pick) * 32'(REL_OVER) |=> !q.picked)
        else $error("over pick-up held below release level");
    a_under_release: assert property (
        q.state == ST_EVAL && q.ctrl.under && q.picked
        && 32'(q.mag) * 32'(PCT_FULL) > 32'(q.pick) * 32'(REL_UNDER) |=> !q.picked)
        else $error("under pick-up held above release level");
    a_over_pickup: assert property (
        q.state == ST_EVAL && !q.ctrl.under && q.mag > MAG_W'(q.pick) |=> q.picked)
        else $error("over pick-up missed");
    a_under_block_level_trip: assert property (
        q.state == ST_EVAL && ub_n |=> !q.trip)
        else $error("trip while undervoltage block engaged");
    a_under_block_level_zero: assert property (
        q.state == ST_EVAL && q.under_block_level == '0 |=> !q.under_block_level_on)
        else $error("block engaged with zero level");
    a_block_sample: assert property (
        q.state == ST_IDLE && q.tick == TICK_LAST |=> q.blk_s == $past(block_in) && q.calc_go)
        else $error("block input not sampled at cycle start");
    a_block_start: assert property (
        q.state == ST_EVAL && pk_n && q.blk_s |=> q.blocked && !q.start ##2 !stage_start)
        else $error("start given while blocked");
    a_cycle_done: assert property (
        q.state == ST_CALC |-> ##[1:100] q.state == ST_IDLE)
        else $error("program cycle evaluation overran");

    c_start: cover property (q.state == ST_EVAL ##1 q.start);
    c_trip: cover property (!q.trip ##1 q.trip);
    c_blocked: cover property (q.state == ST_EVAL ##1 q.blocked);
    c_under_block_level: cover property (!q.under_block_level_on ##1 q.under_block_level_on);
endmodule

// ### testbench.sv
/*
 * Self-checking bench of the sequence voltage stage driven through APB and a phasor model.
 * Assumes one APB wait state and one evaluation per shortened program cycle.
 */
module testbench import seq_volt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 200;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] pick;
        logic [15:0] mag;
        logic neg;
        logic start;
    } row_s;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    logic [15:0] mag = 16'h0000;
    logic neg_order = 1'b0;
    logic blk = 1'b0;
    phasor_s [2:0] phase_fund;
    logic block_in;
    logic stage_start;
    logic stage_trip;
    logic stage_blocked;
    int errors = 0;
    int checked = 0;
    logic [31:0] rd;
    logic err;
    row_s rows [9] = '{
        '{32'h0, 32'h2904, 16'h2ee0, 1'b0, 1'b1},
        '{32'h0, 32'h2904, 16'h283c, 1'b0, 1'b1},
        '{32'h0, 32'h2904, 16'h2328, 1'b0, 1'b0},
        '{32'h2, 32'h2328, 16'h1d4c, 1'b0, 1'b1},
        '{32'h2, 32'h2328, 16'h23f0, 1'b0, 1'b1},
        '{32'h2, 32'h2328, 16'h251c, 1'b0, 1'b0},
        '{32'h1, 32'h2904, 16'h2ee0, 1'b0, 1'b0},
        '{32'h1, 32'h2904, 16'h2ee0, 1'b1, 1'b1},
        '{32'h0, 32'h2904, 16'h2ee0, 1'b1, 1'b0}
    };

    initial forever #5 ref_clk = ~ref_clk;

    sequence_voltage_stage #(.PROG_CYCLE_CYCLES(PC)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .apb(req), .apb_rsp(rsp), .phase_fund(phase_fund), .block_in(block_in),
        .stage_start(stage_start), .stage_trip(stage_trip), .stage_blocked(stage_blocked));
    phase_source src (.ref_clk(ref_clk), .sys_rst(sys_rst), .mag(mag), .neg_order(neg_order),
        .blk(blk), .phase_fund(phase_fund), .block_in(block_in));

    task automatic close_out;
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (n >= 20) begin
            errors++;
            close_out;
        end
    endtask

    task automatic pc(input int k);
        repeat (k * PC) @(posedge ref_clk);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        xfer(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, OFF_PICK, 32'h0);
        chk(rd, 32'h2904);
        xfer(1'b0, OFF_UNDER_BLOCK_LEVEL, 32'h0);
        chk(rd, 32'h1f4);
        // Primary level is not computed before the first evaluation
        pc(2);
        xfer(1'b0, OFF_PRI, 32'h0);
        chk(rd, 32'h41a);
        xfer(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        foreach (rows[i]) begin
            xfer(1'b1, OFF_CTRL, rows[i].ctrl);
            xfer(1'b1, OFF_PICK, rows[i].pick);
            mag <= rows[i].mag;
            neg_order <= rows[i].neg;
            pc(3);
            chk({31'h0, stage_start}, {31'h0, rows[i].start});
        end
        // Block present at the moment of pick-up
        xfer(1'b1, OFF_CTRL, 32'h0);
        mag <= 16'h2ee0;
        neg_order <= 1'b0;
        blk <= 1'b1;
        pc(3);
        chk({30'h0, stage_blocked, stage_start}, 32'h2);
        blk <= 1'b0;
        pc(2);
        chk({31'h0, stage_start}, 32'h1);
        xfer(1'b0, OFF_EXPT, 32'h0);
        chk(rd, 32'h8);
        xfer(1'b0, OFF_RATIO, 32'h0);
        chk(rd, 32'h72);
        pc(10);
        chk({31'h0, stage_trip}, 32'h1);
        // Under block off, then on, then held below pick-up
        xfer(1'b1, OFF_UNDER_BLOCK_LEVEL, 32'h0);
        xfer(1'b1, OFF_CTRL, 32'h2);
        xfer(1'b1, OFF_PICK, 32'h2328);
        mag <= 16'h012c;
        pc(12);
        chk({31'h0, stage_trip}, 32'h1);
        xfer(1'b1, OFF_UNDER_BLOCK_LEVEL, 32'h1f4);
        pc(3);
        chk({31'h0, stage_trip}, 32'h0);
        mag <= 16'h1f40;
        pc(3);
        chk({31'h0, stage_trip}, 32'h0);
        mag <= 16'h251c;
        pc(3);
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, OFF_CTRL, 32'h6 | (s << 3));
            repeat (3) @(posedge ref_clk);
            chk({29'h0, stage_blocked, stage_trip, stage_start}, (32'h1 << s) >> 1);
        end
        // Reset in mid-run while forcing is active
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk({29'h0, stage_blocked, stage_trip, stage_start}, 32'h0);
        xfer(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        close_out;
    end
endmodule
